/* hdl/utr_def_store.sv */
// stored default telegram, one bit per address, registered read
module utr_def_store (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic [utr_pkg::ADDR_W-1:0] rd_addr,
   output logic rd_bit
);

   // fixed content: a scrambled function of the address
   function automatic logic store_bit(input logic [9:0] a);
      logic [15:0] h;
      h = {6'h00, a} ^ utr_pkg::DEF_SEED;
      h = h ^ {h[7:0], h[15:8]};
      h = h ^ {h[12:0], 3'h0};
      return ^h[10:0];
   endfunction

   logic rd_r; // registered read data

   // read port, one cycle latency
   always_ff @(posedge core_clk) begin
      if (rst) begin
         rd_r <= 1'b0;
      end else begin
         rd_r <= store_bit(rd_addr);
      end
   end

   assign rd_bit = rd_r;

endmodule

/* hdl/utr_relay.sv */

package utr_pkg;
   // clock and line rate
   localparam int unsigned CLK_HZ = 40_000_000;
   localparam int unsigned BIT_RATE_HZ = 564_480;
   // whole clock cycles per bit cell, rounded down
   localparam int unsigned BIT_CYC = CLK_HZ / BIT_RATE_HZ;
   // mid-cell edge acceptance window, in cycles
   localparam int unsigned EARLY_CYC = (BIT_CYC * 3) / 4;
   localparam int unsigned LATE_CYC = (BIT_CYC * 5) / 4;
   // edges closer than this after a mid-cell edge are a burst
   localparam int unsigned GUARD_CYC = BIT_CYC / 4;
   localparam int unsigned CNT_W = 8;
   localparam logic [CNT_W-1:0] EARLY_CNT = CNT_W'(EARLY_CYC);
   localparam logic [CNT_W-1:0] LATE_CNT = CNT_W'(LATE_CYC);
   localparam logic [CNT_W-1:0] GUARD_CNT = CNT_W'(GUARD_CYC);
   localparam logic [CNT_W-1:0] TICK_LAST = CNT_W'(BIT_CYC - 1);
   localparam logic [CNT_W-1:0] CNT_MAX = 8'hff;
   // filler run length, inside 75 to 128 bits
   localparam int unsigned FILL_BITS = 100;
   localparam logic [6:0] FILL_LAST = 7'(FILL_BITS - 1);
   localparam logic FILL_LEVEL = 1'b1;
   // bit periods allowed to find lock after energise
   localparam int unsigned ACQ_BITS = 64;
   localparam logic [6:0] ACQ_LAST = 7'(ACQ_BITS - 1);
   // default telegram store
   localparam int unsigned DEF_LEN = 1023;
   localparam int unsigned ADDR_W = 10;
   localparam logic [ADDR_W-1:0] DEF_LAST = ADDR_W'(DEF_LEN - 1);
   localparam logic [ADDR_W-1:0] DEF_FIRST = 10'h000;
   // pattern seed of the stored telegram, arbitrary value
   localparam logic [15:0] DEF_SEED = 16'h5a3c;
   // relay control states
   typedef enum logic [4:0] {
      UTR_IDLE = 5'b00001,
      UTR_ACQ = 5'b00010,
      UTR_RELAY = 5'b00100,
      UTR_FILL = 5'b01000,
      UTR_DFLT = 5'b10000
   } utr_state_type;
endpackage

////////////////////////////////////////////////////////////////////////////

module utr_relay (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic energise,
   input wire logic link_line,
   output logic uplink_bit,
   output logic uplink_strobe,
   output logic uplink_active,
   output logic default_active
);

   ////////////////////////////////////////////////////////////////////////
   // input synchronisers

   logic ener_s1_r; // first stage, read only by second
   logic ener_s2_r; // synchronised energise level
   logic line_s1_r; // first stage, read only by second
   logic line_s2_r; // synchronised line level
   logic line_d_r; // previous line level for edge detect

   // two flops on each pin, then one delay for edges
   always_ff @(posedge core_clk) begin
      if (rst) begin
         ener_s1_r <= 1'b0;
         ener_s2_r <= 1'b0;
         line_s1_r <= 1'b0;
         line_s2_r <= 1'b0;
         line_d_r <= 1'b0;
      end else begin
         ener_s1_r <= energise;
         ener_s2_r <= ener_s1_r;
         line_s1_r <= link_line;
         line_s2_r <= line_s1_r;
         line_d_r <= line_s2_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // differential phase decoder

   logic edge_w; // any line transition
   logic rise_w; // letter of this transition
   logic [utr_pkg::CNT_W-1:0] gap_r, gap_nxt; // cycles since any edge
   logic [utr_pkg::CNT_W-1:0] mid_r, mid_nxt; // cycles since mid-cell edge
   logic locked_r, locked_nxt; // mid-cell phase known
   logic letter_r, letter_nxt; // last letter, 1 for rising
   logic have_r, have_nxt; // a previous letter exists
   logic dec_stb_r, dec_stb_nxt; // one decoded bit ready
   logic dec_bit_r, dec_bit_nxt; // decoded bit value
   logic lost_r, lost_nxt; // lock dropped this cycle

   assign edge_w = line_s2_r ^ line_d_r;
   assign rise_w = line_s2_r;

   // next state of the decoder
   always_comb begin
      gap_nxt = (gap_r == utr_pkg::CNT_MAX) ? gap_r : gap_r + 8'h01;
      mid_nxt = (mid_r == utr_pkg::CNT_MAX) ? mid_r : mid_r + 8'h01;
      locked_nxt = locked_r;
      letter_nxt = letter_r;
      have_nxt = have_r;
      dec_stb_nxt = 1'b0;
      dec_bit_nxt = dec_bit_r;
      lost_nxt = 1'b0;
      if (edge_w) begin
         gap_nxt = 8'h00;
      end
      if (!locked_r) begin
         // a full cell without a boundary edge marks a mid-cell edge
         // a gap longer than a cell follows silence and proves nothing
         if (edge_w && gap_r >= utr_pkg::EARLY_CNT &&
            gap_r <= utr_pkg::LATE_CNT) begin
            locked_nxt = 1'b1;
            letter_nxt = rise_w;
            have_nxt = 1'b1;
            mid_nxt = 8'h00;
         end
      end else if (edge_w && mid_r >= utr_pkg::EARLY_CNT) begin
         dec_stb_nxt = have_r;
         dec_bit_nxt = (letter_r == rise_w);
         letter_nxt = rise_w;
         have_nxt = 1'b1;
         mid_nxt = 8'h00;
      end else if (edge_w && mid_r < utr_pkg::GUARD_CNT) begin
         locked_nxt = 1'b0;
         have_nxt = 1'b0;
         lost_nxt = 1'b1;
      end else if (mid_r > utr_pkg::LATE_CNT) begin
         locked_nxt = 1'b0;
         have_nxt = 1'b0;
         lost_nxt = 1'b1;
      end
   end

   // register the decoder
   always_ff @(posedge core_clk) begin
      if (rst) begin
         gap_r <= 8'h00;
         mid_r <= 8'h00;
         locked_r <= 1'b0;
         letter_r <= 1'b0;
         have_r <= 1'b0;
         dec_stb_r <= 1'b0;
         dec_bit_r <= 1'b0;
         lost_r <= 1'b0;
      end else begin
         gap_r <= gap_nxt;
         mid_r <= mid_nxt;
         locked_r <= locked_nxt;
         letter_r <= letter_nxt;
         have_r <= have_nxt;
         dec_stb_r <= dec_stb_nxt;
         dec_bit_r <= dec_bit_nxt;
         lost_r <= lost_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // default telegram store

   logic [utr_pkg::ADDR_W-1:0] addr_r, addr_nxt; // next stored bit to send
   logic rom_bit; // registered stored bit

   utr_def_store u_store (
      .core_clk(core_clk),
      .rst(rst),
      .rd_addr(addr_r),
      .rd_bit(rom_bit)
   );

   ////////////////////////////////////////////////////////////////////////
   // relay control

   utr_pkg::utr_state_type state_r, state_nxt; // relay state
   logic [utr_pkg::CNT_W-1:0] tick_r, tick_nxt; // local bit period counter
   logic [6:0] cnt_r, cnt_nxt; // acquire and filler bit count
   logic out_bit_r, out_bit_nxt; // bit on the up-link
   logic out_stb_r, out_stb_nxt; // one pulse per up-link bit
   logic tick_w; // local bit period elapsed

   assign tick_w = (tick_r == utr_pkg::TICK_LAST);

   // next state of the relay
   always_comb begin
      state_nxt = state_r;
      tick_nxt = tick_w ? 8'h00 : tick_r + 8'h01;
      cnt_nxt = cnt_r;
      addr_nxt = addr_r;
      out_bit_nxt = out_bit_r;
      out_stb_nxt = 1'b0;
      unique case (state_r)
         utr_pkg::UTR_IDLE: begin
            cnt_nxt = 7'h00;
            tick_nxt = 8'h00;
            if (ener_s2_r) begin
               state_nxt = utr_pkg::UTR_ACQ;
            end
         end
         utr_pkg::UTR_ACQ: begin
            if (locked_r) begin
               state_nxt = utr_pkg::UTR_RELAY;
            end else if (tick_w) begin
               cnt_nxt = cnt_r + 7'h01;
               if (cnt_r == utr_pkg::ACQ_LAST) begin
                  state_nxt = utr_pkg::UTR_FILL;
                  cnt_nxt = 7'h00;
               end
            end
         end
         utr_pkg::UTR_RELAY: begin
            if (dec_stb_r) begin
               out_bit_nxt = dec_bit_r;
               out_stb_nxt = 1'b1;
            end
            if (lost_r) begin
               state_nxt = utr_pkg::UTR_FILL;
               cnt_nxt = 7'h00;
               tick_nxt = 8'h00;
            end
         end
         utr_pkg::UTR_FILL: begin
            if (tick_w) begin
               out_bit_nxt = utr_pkg::FILL_LEVEL;
               out_stb_nxt = 1'b1;
               cnt_nxt = cnt_r + 7'h01;
               if (cnt_r == utr_pkg::FILL_LAST) begin
                  state_nxt = utr_pkg::UTR_DFLT;
                  addr_nxt = utr_pkg::DEF_FIRST;
               end
            end
         end
         utr_pkg::UTR_DFLT: begin
            if (tick_w) begin
               out_bit_nxt = rom_bit;
               out_stb_nxt = 1'b1;
               addr_nxt = (addr_r == utr_pkg::DEF_LAST) ?
                  utr_pkg::DEF_FIRST : addr_r + 10'h001;
            end
         end
      endcase
      if (!ener_s2_r) begin
         state_nxt = utr_pkg::UTR_IDLE;
         out_stb_nxt = 1'b0;
         addr_nxt = utr_pkg::DEF_FIRST;
      end
   end

   // register the relay
   always_ff @(posedge core_clk) begin
      if (rst) begin
         state_r <= utr_pkg::UTR_IDLE;
         tick_r <= 8'h00;
         cnt_r <= 7'h00;
         addr_r <= utr_pkg::DEF_FIRST;
         out_bit_r <= 1'b0;
         out_stb_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         tick_r <= tick_nxt;
         cnt_r <= cnt_nxt;
         addr_r <= addr_nxt;
         out_bit_r <= out_bit_nxt;
         out_stb_r <= out_stb_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // outputs

   assign uplink_bit = out_bit_r;
   assign uplink_strobe = out_stb_r;
   assign uplink_active = (state_r != utr_pkg::UTR_IDLE);
   assign default_active = (state_r == utr_pkg::UTR_FILL) ||
      (state_r == utr_pkg::UTR_DFLT);

endmodule

/* test/tb.sv */
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic core_clk = 1'b0;
   logic rst = 1'b1;
   logic energise = 1'b0;
   logic tx_bit = 1'b0;
   logic mute = 1'b0;
   logic burst = 1'b0;
   logic ones = 1'b0; // force a constant run of ones
   logic flt = 1'b0; // stop noting encoder bits
   logic synced = 1'b0; // relay output seen this activation
   logic def_seen = 1'b0; // default bits already stored
   logic link_line, uplink_bit, uplink_strobe, uplink_active, default_active;
   logic sent_stb, sent_bit;
   logic exp_q[$];
   int tim_q[$];
   logic def_a[16];
   int fail_count = 0;
   int n_tests = 0;
   int cyc = 0;
   int ndef = 0;
   initial forever #12.5 core_clk = ~core_clk;
   utr_relay dut_u (.core_clk, .rst, .energise, .link_line, .uplink_bit,
      .uplink_strobe, .uplink_active, .default_active);
   utr_enc_model enc_u (.core_clk, .tx_bit, .mute, .burst, .link_line,
      .sent_stb, .sent_bit);
   ////////////////////////////////////////
   task automatic check(input logic got, input logic exp);
      n_tests++;
      if (got !== exp) begin
         fail_count++;
         $display("wrong value at %0t: got %b want %b", $time, got, exp);
      end
   endtask
   task automatic complete_run;
      $display("checks %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   // bounded wait for the default phase
   task automatic wait_dflt(input int lim);
      for (int i = 0; i < lim && default_active !== 1'b1; i++)
         @(negedge core_clk);
      check(default_active, 1'b1);
   endtask
   // forget relay notes, expect a full filler run
   task automatic load_fill;
      exp_q.delete();
      tim_q.delete();
      repeat (100) exp_q.push_back(utr_pkg::FILL_LEVEL);
   endtask
   ////////////////////////////////////////
   // random payload, or a constant run from the encoder
   always @(negedge core_clk) tx_bit <= ones | 1'($urandom());
   // note every bit put on the line while flt is low
   always @(negedge core_clk) begin
      cyc <= cyc + 1;
      if (sent_stb === 1'b1 && !flt) begin
         exp_q.push_back(sent_bit);
         tim_q.push_back(cyc);
      end
   end
   // compare each relayed or filler bit with the oldest note, store or compare default bits in def_a
   always @(negedge core_clk) begin
      if (uplink_strobe === 1'b1 && default_active === 1'b0) begin
         while (!synced && tim_q.size() > 0 && tim_q[0] < cyc - 8) begin
            void'(exp_q.pop_front());
            void'(tim_q.pop_front());
         end
         synced = 1'b1;
         if (tim_q.size() == 0) begin
            check(uplink_bit, 1'bx);
         end else begin
            void'(tim_q.pop_front());
            check(uplink_bit, exp_q.pop_front());
         end
      end else if (uplink_strobe === 1'b1 && exp_q.size() > 0) begin
         check(uplink_bit, exp_q.pop_front());
      end else if (uplink_strobe === 1'b1) begin
         if (def_seen && ndef < 16) check(uplink_bit, def_a[ndef]);
         if (ndef < 16) def_a[ndef] = uplink_bit;
         ndef++;
      end
   end
   initial begin
      repeat (100000) @(negedge core_clk);
      check(1'b0, 1'b1);
      complete_run();
   end
   ////////////////////////////////////////
   initial begin
      void'($urandom(32'h4c8803a8));
      repeat (10) @(negedge core_clk);
      rst = 1'b0;
      energise = 1'b1;
      repeat (8000) @(negedge core_clk);
      ones = 1'b1;
      repeat (7100) @(negedge core_clk);
      ones = 1'b0;
      repeat (3000) @(negedge core_clk);
      check(synced, 1'b1);
      // burst on the line: filler, then stored telegram, kept after the line is clean again
      burst = 1'b1;
      wait_dflt(300);
      // stop noting only now: the bit in flight at the burst is relayed
      flt = 1'b1;
      burst = 1'b0;
      load_fill();
      repeat (8300) @(negedge core_clk);
      check(1'(ndef >= 16), 1'b1);
      check(default_active, 1'b1);
      def_seen = 1'b1;
      energise = 1'b0;
      mute = 1'b1;
      repeat (10) @(negedge core_clk);
      check(uplink_active, 1'b0);
      check(default_active, 1'b0);
      // silent line: default telegram from its first bit
      ndef = 0;
      energise = 1'b1;
      wait_dflt(4700);
      load_fill();
      repeat (8300) @(negedge core_clk);
      check(1'(ndef >= 16), 1'b1);
      energise = 1'b0;
      repeat (10) @(negedge core_clk);
      mute = 1'b0;
      flt = 1'b0;
      synced = 1'b0;
      exp_q.delete();
      tim_q.delete();
      energise = 1'b1;
      repeat (7000) @(negedge core_clk);
      check(synced, 1'b1);
      check(default_active, 1'b0);
      complete_run();
   end
endmodule
bind utr_relay utr_chk chk_u (.core_clk, .rst, .energise, .link_line,
   .uplink_bit, .uplink_strobe, .uplink_active, .default_active);

/* test/utr_enc_model.sv */
module utr_enc_model (
   input wire logic core_clk,
   input wire logic tx_bit,
   input wire logic mute,
   input wire logic burst,
   output logic link_line,
   output logic sent_stb,
   output logic sent_bit
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [6:0] cnt_r = 7'h00; // cycle within the cell
   logic [2:0] cell_r = 3'h0; // cell within a group of seven
   logic cur_r = 1'b0; // bit of the current cell
   initial link_line = 1'b0;
   initial sent_stb = 1'b0;
   initial sent_bit = 1'b0;
   ////////////////////////////////////////
   // six cells of 71, one of 70, free running
   always @(posedge core_clk) begin
      cnt_r <= cnt_r + 7'h01;
      if (cnt_r == (cell_r == 3'h6 ? 7'h45 : 7'h46)) begin
         cnt_r <= 7'h00;
         cell_r <= (cell_r == 3'h6) ? 3'h0 : cell_r + 3'h1;
      end
      sent_stb <= 1'b0;
      // boundary edge for a one, mid-cell edge always
      if (!mute && cnt_r == 7'h00) begin
         cur_r <= tx_bit;
         link_line <= tx_bit ? ~link_line : link_line;
      end
      if (!mute && cnt_r == 7'h23) begin
         link_line <= ~link_line;
         sent_stb <= 1'b1;
         sent_bit <= cur_r;
      end
      // commanded burst: two extra edges just after the mid edge
      if (burst && (cnt_r == 7'h28 || cnt_r == 7'h2a)) begin
         link_line <= ~link_line;
      end
   end
endmodule

/* test/utr_relay_chk.sv */
module utr_chk (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic energise,
   input wire logic link_line,
   input wire logic uplink_bit,
   input wire logic uplink_strobe,
   input wire logic uplink_active,
   input wire logic default_active
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (rst);
   // energise held long enough to cross the synchroniser
   sequence s_on;
      energise [*4];
   endsequence
   // a filler bit leaving the relay
   sequence s_fill;
      uplink_strobe && uplink_bit == utr_pkg::FILL_LEVEL;
   endsequence
   AST_ACT_ON: assert property (s_on |-> uplink_active)
      else $error("not active while energised");
   AST_ACT_OFF:
   assert property (!energise [*4] |-> !uplink_active)
      else $error("active while not energised");
   AST_STB_ONE: assert property (uplink_strobe |=> !uplink_strobe)
      else $error("strobe longer than one cycle");
   AST_LATCH: assert property (s_on ##0 default_active |=> default_active)
      else $error("default telegram left while energised");
   AST_FILL_FIRST:
   assert property ($rose(default_active) |-> ##[69:71] s_fill)
      else $error("no filler bit after switch to default");
   AST_DFLT_GAP:
   assert property (s_on ##0 (default_active && uplink_strobe)
      |-> ##70 (uplink_strobe || !default_active))
      else $error("gap in default output");
   AST_RELAY_EDGE:
   assert property (uplink_strobe && !default_active
      |-> $past(link_line, 4) != $past(link_line, 5))
      else $error("relay bit without a line edge");
   AST_BIT_HOLD:
   assert property (!uplink_strobe && uplink_active && $past(uplink_active)
      |-> $stable(uplink_bit))
      else $error("output bit changed between strobes");
endmodule
